// File: lsp_pkg.sv
`default_nettype none
package lsp_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] OFS_P5_LATCH = 8'h05;
	localparam logic [7:0] OFS_P6_LATCH = 8'h06;
	localparam logic [7:0] OFS_P7_LATCH = 8'h07;
	localparam logic [7:0] OFS_P6_DIR = 8'h0c;
	localparam logic [7:0] OFS_P5_PINS = 8'h10;
	localparam logic [7:0] OFS_P7_PINS = 8'h11;
	localparam logic [7:0] OFS_P5_SEL = 8'h2a;
	localparam logic [7:0] OFS_P7_SEL = 8'h2b;
	localparam logic [7:0] OFS_CONV = 8'h30;
	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int unsigned CONV_AIN_DIS_BIT = 0;
	localparam int unsigned KEY_LO_BIT = 4;
	localparam logic [7:0] RST_SEG_LATCH = 8'hff;
	localparam logic [7:0] RST_SEG_SEL = 8'h00;
	localparam logic [7:0] RST_P6_LATCH = 8'h00;
	localparam logic [7:0] RST_P6_DIR = 8'h00;
	localparam logic RST_AIN_DIS = 1'h1;
	localparam logic [7:0] RD_NONE = 8'h00;
	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} lsp_bus_t;
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} lsp_drive_t;
endpackage
`default_nettype wire

// File: lsp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module lsp_sync #(
	parameter int unsigned W = 8
) (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	// first stage feeds only the second
	logic [W-1:0] meta;
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			meta <= '0;
			o_q <= '0;
		end else begin
			meta <= i_d;
			o_q <= meta;
		end
	end
endmodule
`default_nettype wire

// File: lsp_seg_port.sv
`timescale 1ns/1ps
`default_nettype none
module lsp_seg_port (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_wr_latch,
	input wire logic i_wr_sel,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] i_seg,
	output logic [7:0] o_latch,
	output logic [7:0] o_sel,
	output var lsp_pkg::lsp_drive_t o_drive
);
	import lsp_pkg::*;
	// ****************************************
	// latch and segment select
	// ****************************************
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_latch <= RST_SEG_LATCH;
		end else if (i_wr_latch) begin
			o_latch <= i_wdata;
		end
	end
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_sel <= RST_SEG_SEL;
		end else if (i_wr_sel) begin
			o_sel <= i_wdata;
		end
	end
	// ****************************************
	// pin drive
	// ****************************************
	// on a plain port bit (select zero), latch one releases the pin so it can be read back
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_drive <= '0;
		end else begin
			o_drive.out <= o_sel & i_seg;
			o_drive.oe <= o_sel | ~o_latch;
		end
	end
	// ****************************************
	// checks
	// ****************************************
	latch_reset_a: assert property (@(posedge i_core_clk)
		$rose(i_nrst) |-> o_latch == RST_SEG_LATCH)
		else $error("latch not all ones after reset");
	seg_route_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		##1 (o_drive.out & $past(o_sel)) == ($past(i_seg) & $past(o_sel)))
		else $error("segment not routed to pin");
	port_release_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		##1 ($past(o_latch) & ~$past(o_sel) & o_drive.oe) == 8'h00)
		else $error("released port bit still driven");
endmodule
`default_nettype wire

// File: lsp_ports.sv
// Behaviour
// - reset sets port five latch all ones
// - select one routes segment, zero plain port
// - port five latch and pins read separately
// - pin read on segment bits is undefined
// - port six direction one drives latch
// - reset clears port six, sets analog disable
// - disabled analog, latch zero: input reads zero
// - latch one, direction zero passes pin level
// - key wake-up pins need direction zero
// - latch zero, direction zero, analog enabled connects converter
// - analog mode bits read as zero
// - reset sets port seven latch all ones
// - select one routes segment, zero plain port
// - port seven latch and pins read separately
`timescale 1ns/1ps
`default_nettype none
module lsp_ports (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire lsp_pkg::lsp_bus_t i_bus,
	output logic [7:0] o_rdata,
	input wire logic [7:0] i_p5_pin,
	input wire logic [7:0] i_p6_pin,
	input wire logic [7:0] i_p7_pin,
	input wire logic [7:0] i_p5_seg,
	input wire logic [7:0] i_p7_seg,
	output var lsp_pkg::lsp_drive_t o_p5_drive,
	output var lsp_pkg::lsp_drive_t o_p6_drive,
	output var lsp_pkg::lsp_drive_t o_p7_drive,
	output logic [7:0] o_p6_func,
	output logic [3:0] o_key_wakeup,
	output logic [7:0] o_ain_connect,
	output logic o_analog_input_disable
);
	import lsp_pkg::*;

	// ****************************************
	// declarations
	// ****************************************
	logic [7:0] p5_pins;
	logic [7:0] p6_pins;
	logic [7:0] p7_pins;
	logic [7:0] p5_latch;
	logic [7:0] p5_sel;
	logic [7:0] p7_latch;
	logic [7:0] p7_sel;
	logic [7:0] p6_latch;
	logic [7:0] p6_dir;
	logic ain_dis;
	logic [7:0] p6_in;
	logic [7:0] p6_read;
	logic [7:0] next_rdata;
	logic wr_p5_latch;
	logic wr_p5_sel;
	logic wr_p7_latch;
	logic wr_p7_sel;

	// ****************************************
	// pin synchronisers
	// ****************************************
	lsp_sync #(
		.W(8)
	) u_sync5 (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_d(i_p5_pin),
		.o_q(p5_pins)
	);

	lsp_sync #(
		.W(8)
	) u_sync6 (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_d(i_p6_pin),
		.o_q(p6_pins)
	);

	lsp_sync #(
		.W(8)
	) u_sync7 (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_d(i_p7_pin),
		.o_q(p7_pins)
	);

	// ****************************************
	// write decode
	// ****************************************
	assign wr_p5_latch = i_bus.wr && (i_bus.addr == OFS_P5_LATCH);
	assign wr_p5_sel = i_bus.wr && (i_bus.addr == OFS_P5_SEL);
	assign wr_p7_latch = i_bus.wr && (i_bus.addr == OFS_P7_LATCH);
	assign wr_p7_sel = i_bus.wr && (i_bus.addr == OFS_P7_SEL);

	// ****************************************
	// segment-shared ports
	// ****************************************
	lsp_seg_port u_port5 (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_wr_latch(wr_p5_latch),
		.i_wr_sel(wr_p5_sel),
		.i_wdata(i_bus.wdata),
		.i_seg(i_p5_seg),
		.o_latch(p5_latch),
		.o_sel(p5_sel),
		.o_drive(o_p5_drive)
	);

	lsp_seg_port u_port7 (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_wr_latch(wr_p7_latch),
		.i_wr_sel(wr_p7_sel),
		.i_wdata(i_bus.wdata),
		.i_seg(i_p7_seg),
		.o_latch(p7_latch),
		.o_sel(p7_sel),
		.o_drive(o_p7_drive)
	);

	// ****************************************
	// analog-shared port registers
	// ****************************************
	// software must write the whole byte: the latch also picks input modes
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			p6_latch <= RST_P6_LATCH;
		end else if (i_bus.wr && (i_bus.addr == OFS_P6_LATCH)) begin
			p6_latch <= i_bus.wdata;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			p6_dir <= RST_P6_DIR;
		end else if (i_bus.wr && (i_bus.addr == OFS_P6_DIR)) begin
			p6_dir <= i_bus.wdata;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ain_dis <= RST_AIN_DIS;
		end else if (i_bus.wr && (i_bus.addr == OFS_CONV)) begin
			ain_dis <= i_bus.wdata[CONV_AIN_DIS_BIT];
		end
	end

	// ****************************************
	// analog-shared port input path
	// ****************************************
	// latch zero in input direction gives zero, whether fixed or analog
	assign p6_in = p6_pins & p6_latch & ~p6_dir;

	always_comb begin
		p6_read = p6_in;
		for (int i = 0; i < 8; i++) begin
			if (p6_dir[i]) begin
				p6_read[i] = p6_latch[i];
			end
		end
	end

	// ****************************************
	// analog-shared port outputs
	// ****************************************
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_p6_drive <= '0;
		end else begin
			o_p6_drive.out <= p6_latch;
			o_p6_drive.oe <= p6_dir;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_p6_func <= 8'h00;
			o_key_wakeup <= 4'h0;
		end else begin
			o_p6_func <= p6_in;
			o_key_wakeup <= p6_in[KEY_LO_BIT +: 4];
		end
	end

	// converter sees the pin only with analog inputs enabled
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_ain_connect <= 8'h00;
			o_analog_input_disable <= RST_AIN_DIS;
		end else begin
			o_ain_connect <= {8{~ain_dis}} & ~p6_latch & ~p6_dir;
			o_analog_input_disable <= ain_dis;
		end
	end

	// ****************************************
	// read path
	// ****************************************
	// segment bits read the pin as is; value there is undefined
	always_comb begin
		next_rdata = RD_NONE;
		if (i_bus.rd) begin
			case (i_bus.addr)
				OFS_P5_LATCH: next_rdata = p5_latch;
				OFS_P5_PINS: next_rdata = p5_pins;
				OFS_P5_SEL: next_rdata = p5_sel;
				OFS_P6_LATCH: next_rdata = p6_read;
				OFS_P6_DIR: next_rdata = p6_dir;
				OFS_CONV: next_rdata = {7'h00, ain_dis};
				OFS_P7_LATCH: next_rdata = p7_latch;
				OFS_P7_PINS: next_rdata = p7_pins;
				OFS_P7_SEL: next_rdata = p7_sel;
				default: next_rdata = RD_NONE;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= RD_NONE;
		end else begin
			o_rdata <= next_rdata;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	p6_reset_a: assert property (@(posedge i_core_clk)
		$rose(i_nrst) |-> p6_latch == 8'h00 && p6_dir == 8'h00 && ain_dis)
		else $error("port six reset values wrong");

	p6_drive_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		##1 (o_p6_drive.oe == $past(p6_dir))
		&& ((o_p6_drive.out & o_p6_drive.oe) == ($past(p6_latch) & $past(p6_dir))))
		else $error("direction does not drive latch");

	fixed_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(ain_dis && p6_latch[0] == 1'h0 && !p6_dir[0]) |=> o_p6_func[0] == 1'h0)
		else $error("fixed input not zero");

	input_pass_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(p6_latch[4] && !p6_dir[4]) |=> o_p6_func[4] == $past(p6_pins[4]))
		else $error("pin level not passed to function");

	ain_link_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(!ain_dis && !p6_latch[7] && !p6_dir[7]) |=> o_ain_connect[7])
		else $error("converter link wrong");

	ain_off_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		ain_dis |=> o_ain_connect == 8'h00)
		else $error("converter linked while disabled");

	ain_read_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(i_bus.rd && i_bus.addr == OFS_P6_LATCH)
		|=> (o_rdata & ~$past(p6_latch) & ~$past(p6_dir)) == 8'h00)
		else $error("analog bit did not read zero");

	latch_read_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(i_bus.rd && i_bus.addr == OFS_P5_LATCH) |=> o_rdata == $past(p5_latch))
		else $error("port five latch read wrong");

	pin_read_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(i_bus.rd && i_bus.addr == OFS_P7_PINS) |=> o_rdata == $past(p7_pins))
		else $error("port seven pin read wrong");

	idle_read_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		!i_bus.rd |=> o_rdata == RD_NONE)
		else $error("read data without strobe");

	p5_latch_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		wr_p5_latch |=> p5_latch == $past(i_bus.wdata)
		##1 o_p5_drive.oe[0] == ($past(p5_sel[0]) | ~$past(p5_latch[0])))
		else $error("port five latch not taken");

	out_reset_a: assert property (@(posedge i_core_clk)
		$rose(i_nrst) |-> o_rdata == RD_NONE && o_p6_func == 8'h00 && o_key_wakeup == 4'h0)
		else $error("outputs not cleared by reset");

	dis_copy_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		##1 o_analog_input_disable == $past(ain_dis))
		else $error("disable copy wrong");

	key_wake_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(p6_latch[KEY_LO_BIT] && !p6_dir[KEY_LO_BIT])
		|=> o_key_wakeup[0] == $past(p6_pins[KEY_LO_BIT]))
		else $error("key wake-up input not passed");

	// output bits never reach the secondary functions
	func_dir_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		##1 (o_p6_func & $past(p6_dir)) == 8'h00)
		else $error("output bit reached function");

	p6_read_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(i_bus.rd && i_bus.addr == OFS_P6_LATCH)
		|=> ((o_rdata ^ $past(p6_latch)) & $past(p6_dir)) == 8'h00)
		else $error("output bit did not read latch");

	dir_read_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(i_bus.rd && i_bus.addr == OFS_P6_DIR) |=> o_rdata == $past(p6_dir))
		else $error("direction read wrong");

	conv_read_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(i_bus.rd && i_bus.addr == OFS_CONV) |=> o_rdata == {7'h00, $past(ain_dis)})
		else $error("converter control read wrong");

	sel_read_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(i_bus.rd && i_bus.addr == OFS_P5_SEL) |=> o_rdata == $past(p5_sel))
		else $error("port five select read wrong");

	p7_sel_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(i_bus.rd && i_bus.addr == OFS_P7_SEL) |=> o_rdata == $past(p7_sel))
		else $error("port seven select read wrong");

	p7_latch_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(i_bus.rd && i_bus.addr == OFS_P7_LATCH) |=> o_rdata == $past(p7_latch))
		else $error("port seven latch read wrong");

	// segment bits are masked: their pin level is undefined
	p5_pins_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(i_bus.rd && i_bus.addr == OFS_P5_PINS)
		|=> (o_rdata & ~$past(p5_sel)) == ($past(p5_pins) & ~$past(p5_sel)))
		else $error("port five pin read wrong");

	pins_wr_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		(i_bus.wr && i_bus.addr == OFS_P5_PINS) |=> $stable(p5_latch) && $stable(p5_sel))
		else $error("pin address write changed port five");

	// ****************************************
	// coverage
	// ****************************************
	key_cov: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
		o_key_wakeup != 4'h0);
	analog_cov: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
		!ain_dis && o_ain_connect != 8'h00);
	seg_cov: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
		p5_sel != 8'h00 && p7_sel != 8'h00);
	out_cov: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
		o_p6_drive.oe != 8'h00 ##1 i_bus.rd && i_bus.addr == OFS_P6_LATCH);
endmodule
`default_nettype wire

// File: lsp_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// outside world: pins and segment driver
// ****************************************
module lsp_pin_model (
	input wire lsp_pkg::lsp_drive_t i_p5_drive,
	input wire lsp_pkg::lsp_drive_t i_p6_drive,
	input wire lsp_pkg::lsp_drive_t i_p7_drive,
	input wire logic [7:0] i_ext5,
	input wire logic [7:0] i_ext6,
	input wire logic [7:0] i_ext7,
	input wire logic [7:0] i_seg_pat,
	output logic [7:0] o_p5_pin,
	output logic [7:0] o_p6_pin,
	output logic [7:0] o_p7_pin,
	output logic [7:0] o_p5_seg,
	output logic [7:0] o_p7_seg
);
	import lsp_pkg::*;
	// driven bits win, released bits show the outside level
	function automatic logic [7:0] resolve(input lsp_drive_t d, input logic [7:0] ext);
		return (d.oe & d.out) | (~d.oe & ext);
	endfunction
	assign o_p5_pin = resolve(i_p5_drive, i_ext5);
	assign o_p6_pin = resolve(i_p6_drive, i_ext6);
	assign o_p7_pin = resolve(i_p7_drive, i_ext7);
	// distinct patterns so a swapped route shows
	assign o_p5_seg = i_seg_pat;
	assign o_p7_seg = ~i_seg_pat;
endmodule
`default_nettype wire

// File: lsp_ports_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lsp_ports_tb;
	import lsp_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	lsp_bus_t bus = '0;
	logic [7:0] rdata, p5_pin, p6_pin, p7_pin, p5_seg, p7_seg, func, ain;
	logic [7:0] ext5 = 8'h9c;
	logic [7:0] ext6 = 8'hff;
	logic [7:0] ext7 = 8'h63;
	logic [7:0] seg_pat = 8'ha5;
	logic [3:0] key;
	logic dis;
	lsp_drive_t p5_drive, p6_drive, p7_drive;
	int mismatches = 0;
	int total_checks = 0;
	always #2.5 clk = ~clk;
	lsp_ports u_dut (.i_core_clk(clk), .i_nrst(nrst), .i_bus(bus), .o_rdata(rdata),
		.i_p5_pin(p5_pin), .i_p6_pin(p6_pin), .i_p7_pin(p7_pin), .i_p5_seg(p5_seg),
		.i_p7_seg(p7_seg), .o_p5_drive(p5_drive), .o_p6_drive(p6_drive),
		.o_p7_drive(p7_drive), .o_p6_func(func), .o_key_wakeup(key),
		.o_ain_connect(ain), .o_analog_input_disable(dis));
	lsp_pin_model u_pins (.i_p5_drive(p5_drive), .i_p6_drive(p6_drive),
		.i_p7_drive(p7_drive), .i_ext5(ext5), .i_ext6(ext6), .i_ext7(ext7),
		.i_seg_pat(seg_pat), .o_p5_pin(p5_pin), .o_p6_pin(p6_pin), .o_p7_pin(p7_pin),
		.o_p5_seg(p5_seg), .o_p7_seg(p7_seg));
	// ****************************************
	// tasks
	// ****************************************
	task automatic wrap_up();
		if (mismatches == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
		total_checks++;
		if ((got & m) !== (exp & m)) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
	// undefined bits are masked out of the compare
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1;
		chk(rdata, e, m);
	endtask
	task automatic reset_reads();
		rd(OFS_P5_LATCH, 8'hff, 8'hff);
		rd(OFS_P7_LATCH, 8'hff, 8'hff);
		rd(OFS_P5_SEL, 8'h00, 8'hff);
		rd(OFS_P6_DIR, 8'h00, 8'hff);
		rd(OFS_P6_LATCH, 8'h00, 8'hff);
		rd(OFS_CONV, 8'h01, 8'hff);
		chk({7'h00, dis}, 8'h01, 8'hff);
		chk(ain, 8'h00, 8'hff);
		chk(p6_drive.oe, 8'h00, 8'hff);
		chk(p5_drive.oe, 8'h00, 8'hff);
	endtask
	// ****************************************
	// sequence
	// ****************************************
	initial begin
		logic [7:0] lat, sel, pin, sg;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		tick(4);
		reset_reads();
		for (int k = 0; k < 2; k++) begin
			lat = k ? OFS_P7_LATCH : OFS_P5_LATCH;
			sel = k ? OFS_P7_SEL : OFS_P5_SEL;
			pin = k ? OFS_P7_PINS : OFS_P5_PINS;
			sg = k ? ~seg_pat : seg_pat;
			wr(sel, 8'h0f);
			wr(lat, 8'h70);
			tick(4);
			chk(k ? p7_drive.out : p5_drive.out, sg & 8'h0f, 8'hff);
			chk(k ? p7_drive.oe : p5_drive.oe, 8'h8f, 8'hff);
			rd(lat, 8'h70, 8'hff);
			rd(sel, 8'h0f, 8'hff);
			rd(pin, (k ? ext7 : ext5) & 8'h70, 8'hf0);
		end
		@(posedge clk);
		seg_pat <= 8'h5a;
		tick(2);
		chk(p5_drive.out, 8'h0a, 8'hff);
		@(posedge clk);
		ext6 <= 8'hd0;
		wr(OFS_P6_DIR, 8'h0f);
		wr(OFS_P6_LATCH, 8'h35);
		tick(4);
		chk(p6_drive.out, 8'h35, 8'hff);
		chk(p6_drive.oe, 8'h0f, 8'hff);
		chk(func, 8'h10, 8'hff);
		chk({4'h0, key}, 8'h01, 8'hff);
		chk(ain, 8'h00, 8'hff);
		rd(OFS_P6_LATCH, 8'h15, 8'hff);
		wr(OFS_CONV, 8'h00);
		tick(3);
		chk(ain, 8'hc0, 8'hff);
		chk({7'h00, dis}, 8'h00, 8'hff);
		rd(OFS_CONV, 8'h00, 8'hff);
		rd(OFS_P6_LATCH, 8'h15, 8'hff);
		tick(1);
		chk(rdata, 8'h00, 8'hff);
		wr(8'h3f, 8'hff);
		wr(OFS_P5_PINS, 8'h00);
		rd(8'h3f, 8'h00, 8'hff);
		rd(OFS_P5_LATCH, 8'h70, 8'hff);
		@(posedge clk);
		ext6 <= 8'hff;
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		tick(4);
		reset_reads();
		wrap_up();
	end
	initial begin
		#20000;
		mismatches++;
		wrap_up();
	end
endmodule
`default_nettype wire
